// ==== design/bssc_exec.sv ====
// executor for bit-set, bit-test-skip-if-one and subroutine call
// assumes instr is stable for a whole instruction cycle and that
// reg_rdata answers reg_addr combinationally by phase 2
//
// Summary of operation
// RQ1: bit set forces bit, flags untouched
// RQ2: tested bit zero: next instruction runs
// RQ3: tested bit one: next becomes no-op
// RQ4: skip costs one extra all-idle cycle
// RQ5: call pushes pc+1, loads literal and latch
`default_nettype none
`include "bssc_cfg.svh"
module bssc_exec
  import bssc_pkg::*;
#(
  parameter int STACK_DEPTH = `BSSC_STACK_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [13:0] instr,
  input wire logic [7:0] reg_rdata,
  input wire logic [4:0] pc_upper_latch,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_we,
  output logic [12:0] pc_q,
  output logic [12:0] stack_top,
  output logic [1:0] phase_q,
  output logic cycle_start,
  output logic busy_q
);
  bssc_state_t state_q;
  logic [7:0] data_q;
  logic [12:0] pc_inc;
  logic is_bit, is_set, is_skip, is_call, push;

  function automatic logic [1:0] sub_op(input logic [13:0] w);
    return w[`BSSC_SUB_MSB:`BSSC_SUB_LSB];
  endfunction

  assign is_bit = instr[`BSSC_OP_HI_MSB:`BSSC_OP_HI_LSB] == `BSSC_OP_BIT;
  assign is_set = is_bit && sub_op(instr) == `BSSC_SUB_SET;
  assign is_skip = is_bit && sub_op(instr) == `BSSC_SUB_SKIP;
  assign is_call = instr[`BSSC_OP_HI_MSB:`BSSC_OP_HI_LSB] == `BSSC_OP_CALL;
  assign pc_inc = 13'(pc_q + 1'b1);
  assign push = state_q == BSSC_EXEC && is_call && phase_q == 2'h3;

  // four phases per instruction cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 2'h0;
      cycle_start <= 1'b1;
    end else begin
      phase_q <= 2'(phase_q + 1'b1);
      cycle_start <= phase_q == 2'h3;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_addr <= '0;
    end else if (phase_q == 2'h0) begin
      reg_addr <= instr[`BSSC_FADDR_MSB:0];
    end
  end

  // read in phase 2 only; status flags are never driven from here
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= '0;
    end else if (phase_q == 2'h1 && state_q == BSSC_EXEC) begin
      data_q <= reg_rdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_we <= 1'b0;
      reg_wdata <= '0;
    end else begin
      reg_we <= 1'b0;
      if (phase_q == 2'h2 && state_q == BSSC_EXEC && is_set) begin
        reg_we <= 1'b1; // RQ1
        reg_wdata <= data_q | (8'h01 << instr[`BSSC_BIT_MSB:`BSSC_BIT_LSB]); // RQ1
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= BSSC_EXEC;
      busy_q <= 1'b0;
    end else if (phase_q == 2'h3) begin
      case (state_q)
        BSSC_EXEC: begin
          if (is_skip && data_q[instr[`BSSC_BIT_MSB:`BSSC_BIT_LSB]]) begin
            state_q <= BSSC_NOP; // RQ3
            busy_q <= 1'b1; // RQ4
          end else if (is_call) begin
            state_q <= BSSC_CALL2; // RQ5
            busy_q <= 1'b1;
          end else begin
            state_q <= BSSC_EXEC; // RQ2
            busy_q <= 1'b0;
          end
        end
        BSSC_NOP, BSSC_CALL2: begin
          state_q <= BSSC_EXEC; // RQ4
          busy_q <= 1'b0;
        end
        default: begin
          state_q <= BSSC_EXEC;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // pc advances once per cycle except in the call's second cycle, the call loads its target at phase 4
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= '0;
    end else if (phase_q == 2'h3) begin
      if (state_q == BSSC_EXEC && is_call) begin
        pc_q <= {pc_upper_latch[`BSSC_LATCH_MSB:`BSSC_LATCH_LSB],
                 instr[`BSSC_LIT_MSB:0]}; // RQ5
      end else if (state_q != BSSC_CALL2) begin
        pc_q <= pc_inc;
      end
    end
  end

  bssc_stack #(.DEPTH(STACK_DEPTH), .WIDTH(13)) u_stack (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .push(push), // RQ5
    .push_data(pc_inc),
    .top_q(stack_top)
  );

  a_set_writes_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_we |-> state_q == BSSC_EXEC && is_set && phase_q == 2'h3) // RQ1
    else $error("bit write outside a bit-set phase 4");
  a_noskip_on_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (phase_q == 2'h3 && state_q == BSSC_EXEC && is_skip &&
     !data_q[instr[9:7]]) |=> state_q == BSSC_EXEC) // RQ2
    else $error("skip taken on zero bit");
  a_skip_on_one: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (phase_q == 2'h3 && state_q == BSSC_EXEC && is_skip &&
     data_q[instr[9:7]]) |=> state_q == BSSC_NOP) // RQ3
    else $error("skip missed on one bit");
  a_nop_no_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == BSSC_NOP |-> !reg_we) // RQ4
    else $error("write during skipped cycle");
  a_nop_one_cycle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(state_q == BSSC_NOP) |-> (state_q == BSSC_NOP)[*4] ##1 state_q == BSSC_EXEC) // RQ4
    else $error("skipped cycle not exactly one instruction cycle");
  a_call_target: assert property (@(posedge ref_clk) disable iff (!rst_n)
    push |=> pc_q == {$past(pc_upper_latch[4:3]), $past(instr[10:0])}) // RQ5
    else $error("call target wrong");
  a_call_push: assert property (@(posedge ref_clk) disable iff (!rst_n)
    push |=> stack_top == 13'($past(pc_q) + 1'b1)) // RQ5
    else $error("call return address wrong");
  a_call_two_cycles: assert property (@(posedge ref_clk) disable iff (!rst_n)
    push |=> (state_q == BSSC_CALL2)[*4] ##1 state_q == BSSC_EXEC) // RQ5
    else $error("call not two cycles");
endmodule
`default_nettype wire

// ==== include/bssc_cfg.svh ====
// timing and field constants for the bit-set / skip / call executor
// assumes the includer owns the phase counter and ref_clk domain
`ifndef BSSC_CFG_SVH
`define BSSC_CFG_SVH
`define BSSC_OP_HI_MSB 13
`define BSSC_OP_HI_LSB 12
`define BSSC_OP_BIT 2'h1
`define BSSC_OP_CALL 2'h2
`define BSSC_SUB_MSB 11
`define BSSC_SUB_LSB 10
`define BSSC_SUB_SET 2'h1
`define BSSC_SUB_SKIP 2'h3
`define BSSC_BIT_MSB 9
`define BSSC_BIT_LSB 7
`define BSSC_FADDR_MSB 6
`define BSSC_LIT_MSB 10
`define BSSC_LATCH_MSB 4
`define BSSC_LATCH_LSB 3
`define BSSC_PHASES 4
`define BSSC_STACK_DEPTH 8
`endif

// ==== include/bssc_pkg.sv ====
// types for the bit-set / skip / call executor
// assumes bssc_cfg.svh is available on the include path
`default_nettype none
package bssc_pkg;
  typedef enum logic [1:0] {BSSC_EXEC, BSSC_NOP, BSSC_CALL2} bssc_state_t;
  typedef logic [12:0] bssc_pc_t;
endpackage
`default_nettype wire

// ==== design/bssc_stack.sv ====
// hardware return-address stack, circular, registered top output
// assumes push and pop never occur in the same cycle
`default_nettype none
module bssc_stack #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 13
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  output logic [WIDTH-1:0] top_q
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] ptr_q;

  // overflow wraps silently, like the original core
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= '0;
    end else if (push) begin
      ptr_q <= AW'(ptr_q + 1'b1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (push) begin
      mem_q[ptr_q] <= push_data;
    end
  end

  // a push bypasses the array so the top is current one cycle after it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      top_q <= '0;
    end else begin
      top_q <= push ? push_data : mem_q[AW'(ptr_q - 1'b1)];
    end
  end
endmodule
`default_nettype wire

// ==== bench/bssc_regfile_model.sv ====
// register file seen by the executor: combinational read, write on clock
// assumes the bench may preload cells through the hierarchy
`default_nettype none
module bssc_regfile_model (
  input wire logic ref_clk,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  output logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:127];
  assign reg_rdata = mem[reg_addr];
  // plain always so the bench can also preload cells
  always @(posedge ref_clk) begin
    if (reg_we) begin
      mem[reg_addr] <= reg_wdata;
    end
  end
endmodule
`default_nettype wire

// ==== bench/bit_set_skip_call_exec_test.sv ====
// self-checking bench for the bit-set / skip / call executor
// assumes one instruction word issued per four-phase cycle
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module bit_set_skip_call_exec_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst_n = 0;
  logic [13:0] instr = 14'h0000;
  logic [4:0] pc_upper_latch = 5'h00;
  logic [7:0] reg_rdata, reg_wdata;
  logic [6:0] reg_addr;
  logic reg_we, cycle_start, busy_q;
  logic [12:0] pc_q, stack_top, p;
  logic [1:0] phase_q;
  int n_errors = 0, checks = 0;
  always #10 ref_clk = ~ref_clk;
  bssc_exec uut (.ref_clk(ref_clk), .rst_n(rst_n), .instr(instr), .reg_rdata(reg_rdata),
    .pc_upper_latch(pc_upper_latch), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .pc_q(pc_q), .stack_top(stack_top), .phase_q(phase_q),
    .cycle_start(cycle_start), .busy_q(busy_q));
  bssc_regfile_model rf (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_rdata(reg_rdata));
  // issue a word at the edge that opens the next instruction cycle
  task automatic cyc(input logic [13:0] w);
    @(posedge ref_clk);
    #1;
    while (phase_q !== 2'h3) begin
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    instr <= w;
    #1;
  endtask
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic t_set;
    rf.mem[7'h15] = 8'h0a;
    rf.mem[7'h16] = 8'h00;
    cyc(14'h1795);
    cyc(14'h0000);
    `CHK(rf.mem[7'h15], 8'h8a)
    `CHK(phase_q, 2'h0)
    `CHK(cycle_start, 1'b1)
    $display("bit set done");
  endtask
  task automatic t_skip;
    cyc(14'h1c15);
    p = pc_q;
    cyc(14'h1496);
    `CHK(busy_q, 1'b0)
    `CHK(pc_q, p + 13'h0001)
    cyc(14'h0000);
    `CHK(rf.mem[7'h16], 8'h02)
    cyc(14'h1f95);
    p = pc_q;
    cyc(14'h1516);
    `CHK(busy_q, 1'b1)
    cyc(14'h0000);
    `CHK(rf.mem[7'h16], 8'h02)
    `CHK(busy_q, 1'b0)
    `CHK(pc_q, p + 13'h0002)
    $display("skip done");
  endtask
  task automatic t_call;
    @(posedge ref_clk);
    pc_upper_latch <= 5'h18;
    cyc(14'h2123);
    p = pc_q;
    cyc(14'h0000);
    `CHK(busy_q, 1'b1)
    cyc(14'h0000);
    `CHK(pc_q, 13'h1923)
    `CHK(stack_top, p + 13'h0001)
    $display("call done");
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_set();
    t_skip();
    t_call();
    give_verdict();
  end
  // whole run needs well under 100 instruction cycles
  initial begin
    #20us;
    n_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
